// ---- rtl/adcms_top.sv ----
// adcms_top: converter sequencer, result scaling, current averaging and
// the two high-voltage comparator flag paths.
// assumes synchronous inputs, an external converter that pulses
// adc_done with adc_data valid, and host/trim requesters on plain ports.
`timescale 1ns/100ps

module adcms_top #(
  parameter int FILT_CYCLES = adcms_pkg::FILT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  // host request side
  input wire logic host_req,
  input wire logic [1:0] host_src,
  input wire logic [adcms_pkg::VSEL_W-1:0] host_vsel,
  input wire logic host_att_hi,
  output logic host_busy,
  output logic host_done,
  output logic [adcms_pkg::RES_HI_W-1:0] result_hi,
  output logic [adcms_pkg::RES_LO_W-1:0] result_lo,
  // trim loop request side
  input wire logic trim_req,
  input wire logic [adcms_pkg::VSEL_W-1:0] trim_vsel,
  input wire logic trim_att_hi,
  output logic trim_busy,
  output logic trim_done,
  output logic [adcms_pkg::RES_W-1:0] trim_result,
  // periodic current schedule
  input wire logic sched_en,
  input wire logic [adcms_pkg::PER_W-1:0] sched_period,
  output logic [adcms_pkg::RES_W-1:0] hs_cur_avg,
  output logic [adcms_pkg::RES_W-1:0] lv_cur_avg,
  // converter
  output logic adc_start,
  output logic [1:0] adc_src,
  output logic [adcms_pkg::VSEL_W-1:0] adc_vsel,
  output logic [1:0] adc_att,
  input wire logic adc_done,
  input wire logic [adcms_pkg::RAW_W-1:0] adc_data,
  // high-voltage comparators
  input wire logic [adcms_pkg::THR_W-1:0] hv_code_a,
  input wire logic [adcms_pkg::THR_W-1:0] hv_code_b,
  input wire logic hv_window_en,
  input wire logic hv_filt_en,
  input wire logic hv_cmp_a,
  input wire logic hv_cmp_b,
  output logic [adcms_pkg::THR_W-1:0] hv_ref_a,
  output logic [adcms_pkg::THR_W-1:0] hv_ref_b,
  output logic hv_flag_a,
  output logic hv_flag_b
);
  import adcms_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (FILT_CYCLES < 2 || FILT_CYCLES > 65535) begin : g_bad_filt
    $error("FILT_CYCLES out of range");
  end

  typedef enum logic [1:0] {
    OWN_HOST,
    OWN_TRIM,
    OWN_HS,
    OWN_LV
  } adcms_own_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_CONV
  } adcms_st_e;

  // ----------------------------------------------------------------
  // request latches
  // ----------------------------------------------------------------
  logic host_pend_q, host_pend_d;
  logic trim_pend_q, trim_pend_d;
  logic hs_pend_q, hs_pend_d;
  logic lv_pend_q, lv_pend_d;
  logic [1:0] host_src_q;
  logic [VSEL_W-1:0] host_vsel_q, trim_vsel_q;
  logic host_att_q, trim_att_q;
  logic [PER_W-1:0] tick_q;
  logic tick_hit;
  adcms_st_e st_q, st_d;
  adcms_own_e own_q, own_d;
  logic grant;
  logic host_take, trim_take;

  // a request made while still busy is refused; busy shows it
  assign host_take = host_req & ~host_busy;
  assign trim_take = trim_req & ~trim_busy;
  assign tick_hit = sched_en && (tick_q >= sched_period);
  assign grant = (st_q == ST_IDLE) &&
                 (host_pend_q | trim_pend_q | hs_pend_q | lv_pend_q);

  // host first, then trim, then the background current pair
  assign own_d = host_pend_q ? OWN_HOST :
                 trim_pend_q ? OWN_TRIM :
                 hs_pend_q ? OWN_HS : OWN_LV;

  // a new arrival beats the clearing grant
  assign host_pend_d = host_take | (host_pend_q & ~(grant &&
                       own_d == OWN_HOST));
  assign trim_pend_d = trim_take | (trim_pend_q & ~(grant &&
                       own_d == OWN_TRIM));
  // background conversions only while nobody else waits
  assign hs_pend_d = tick_hit | (hs_pend_q & ~(grant && own_d == OWN_HS));
  assign lv_pend_d = tick_hit | (lv_pend_q & ~(grant && own_d == OWN_LV));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_pend_q <= 1'b0;
      trim_pend_q <= 1'b0;
      hs_pend_q <= 1'b0;
      lv_pend_q <= 1'b0;
    end else begin
      host_pend_q <= host_pend_d;
      trim_pend_q <= trim_pend_d;
      hs_pend_q <= hs_pend_d;
      lv_pend_q <= lv_pend_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_src_q <= 2'h0;
      host_vsel_q <= '0;
      host_att_q <= 1'b0;
      trim_vsel_q <= '0;
      trim_att_q <= 1'b0;
    end else begin
      if (host_take) begin
        host_src_q <= host_src;
        host_vsel_q <= host_vsel;
        host_att_q <= host_att_hi;
      end
      if (trim_take) begin
        trim_vsel_q <= trim_vsel;
        trim_att_q <= trim_att_hi;
      end
    end
  end

  // schedule tick; period 0 converts as fast as the arbiter allows
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= '0;
    end else if (!sched_en || tick_hit) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // channel setup: selector and attenuation per owner
  // ----------------------------------------------------------------
  logic [1:0] src_d, att_d;
  logic [VSEL_W-1:0] vsel_d;
  logic [1:0] host_att_code;

  // vsense: div3 or div1; high voltage: div8 or div4
  assign host_att_code =
    (host_src_q == ADCMS_SRC_HV) ?
      (host_att_q ? ADCMS_ATT_DIV8 : ADCMS_ATT_DIV4) :
    (host_src_q == ADCMS_SRC_VSENSE) ?
      (host_att_q ? ADCMS_ATT_DIV3 : ADCMS_ATT_DIV1) : ADCMS_ATT_DIV1;

  // trim loop always measures through the vsense selector
  assign src_d = (own_d == OWN_HOST) ? host_src_q :
                 (own_d == OWN_TRIM) ? ADCMS_SRC_VSENSE :
                 (own_d == OWN_HS) ? ADCMS_SRC_HS_CUR : ADCMS_SRC_LV_CUR;
  assign vsel_d = (own_d == OWN_HOST) ? host_vsel_q :
                  (own_d == OWN_TRIM) ? trim_vsel_q : '0;
  assign att_d = (own_d == OWN_HOST) ? host_att_code :
                 (own_d == OWN_TRIM) ?
                   (trim_att_q ? ADCMS_ATT_DIV3 : ADCMS_ATT_DIV1) :
                 ADCMS_ATT_DIV1;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (grant) st_d = ST_SETUP;
      end
      ST_SETUP: begin
        st_d = ST_CONV;
      end
      ST_CONV: begin
        if (adc_done) st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // selector settles one cycle before the start pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      own_q <= OWN_HOST;
      adc_src <= 2'h0;
      adc_vsel <= '0;
      adc_att <= 2'h0;
      adc_start <= 1'b0;
    end else begin
      st_q <= st_d;
      adc_start <= (st_q == ST_SETUP);
      if (grant) begin
        own_q <= own_d;
        adc_src <= src_d;
        adc_vsel <= vsel_d;
        adc_att <= att_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // scaling to 2 mV per LSB
  // ----------------------------------------------------------------
  logic [3:0] mul;
  logic [RES_W-1:0] scaled;

  // current sources keep x1 since their attenuation is div1
  assign mul = (adc_att == ADCMS_ATT_DIV8) ? MUL_DIV8 :
               (adc_att == ADCMS_ATT_DIV4) ? MUL_DIV4 :
               (adc_att == ADCMS_ATT_DIV3) ? MUL_DIV3 : MUL_DIV1;
  // 1023 * 8 fits in 13 bits, so nothing is lost
  assign scaled = RES_W'({3'h0, adc_data} * {9'h000, mul});

  logic fin;
  assign fin = (st_q == ST_CONV) && adc_done;

  // ----------------------------------------------------------------
  // result capture per requester
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_done <= 1'b0;
      trim_done <= 1'b0;
      result_hi <= '0;
      result_lo <= '0;
      trim_result <= '0;
    end else begin
      host_done <= fin && (own_q == OWN_HOST);
      trim_done <= fin && (own_q == OWN_TRIM);
      if (fin && own_q == OWN_HOST) begin
        result_hi <= scaled[RES_W-1:RES_LO_W];
        result_lo <= scaled[RES_LO_W-1:0];
      end
      if (fin && own_q == OWN_TRIM) trim_result <= scaled;
    end
  end

  // busy from take until the done pulse
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_busy <= 1'b0;
      trim_busy <= 1'b0;
    end else begin
      host_busy <= host_take | (host_busy &
                   ~(fin && own_q == OWN_HOST));
      trim_busy <= trim_take | (trim_busy &
                   ~(fin && own_q == OWN_TRIM));
    end
  end

  // ----------------------------------------------------------------
  // eight-sample weighted average: avg += (sample - avg) / 8
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] hs_acc_q, lv_acc_q;
  logic [ACC_W-1:0] hs_acc_d, lv_acc_d;

  // the accumulator keeps three fraction bits so small steps survive
  assign hs_acc_d = hs_acc_q - (hs_acc_q >> AVG_SHIFT) + ACC_W'(scaled);
  assign lv_acc_d = lv_acc_q - (lv_acc_q >> AVG_SHIFT) + ACC_W'(scaled);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hs_acc_q <= '0;
      lv_acc_q <= '0;
      hs_cur_avg <= '0;
      lv_cur_avg <= '0;
    end else begin
      if (fin && own_q == OWN_HS) begin
        hs_acc_q <= hs_acc_d;
        hs_cur_avg <= hs_acc_d[ACC_W-1:AVG_SHIFT];
      end
      if (fin && own_q == OWN_LV) begin
        lv_acc_q <= lv_acc_d;
        lv_cur_avg <= lv_acc_d[ACC_W-1:AVG_SHIFT];
      end
    end
  end

  // ----------------------------------------------------------------
  // high-voltage comparators: threshold, window, glitch filter
  // ----------------------------------------------------------------
  logic [1:0] cmp_in;
  logic [1:0] flag_q;
  logic [THR_W-1:0] code_in [2];
  logic [THR_W-1:0] ref_q [2];

  // window mode reports b and not a on the a flag
  assign cmp_in[0] = hv_window_en ? (hv_cmp_b & ~hv_cmp_a) : hv_cmp_a;
  assign cmp_in[1] = hv_cmp_b;
  assign code_in[0] = hv_code_a;
  assign code_in[1] = hv_code_b;

  for (genvar i = 0; i < 2; i++) begin : g_cmp
    logic [15:0] cnt_q;
    logic differ;
    assign differ = cmp_in[i] != flag_q[i];
    // codes past the last level clamp to it
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        ref_q[i] <= THR_RST;
      end else begin
        ref_q[i] <= (code_in[i] > THR_MAX) ? THR_MAX : code_in[i];
      end
    end
    // filtered: change only after FILT_CYCLES stable cycles
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        cnt_q <= '0;
        flag_q[i] <= 1'b0;
      end else if (!differ) begin
        cnt_q <= '0;
      end else if (!hv_filt_en ||
                   cnt_q == 16'(FILT_CYCLES - 1)) begin
        cnt_q <= '0;
        flag_q[i] <= cmp_in[i];
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign hv_ref_a = ref_q[0];
  assign hv_ref_b = ref_q[1];
  assign hv_flag_a = flag_q[0];
  assign hv_flag_b = flag_q[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_grant;
    st_q == ST_IDLE ##1 st_q == ST_SETUP;
  endsequence
  sequence s_start;
    adc_start && st_q == ST_CONV;
  endsequence

  chk_setup_start: assert property (
    s_grant |=> s_start ##0 ($stable(adc_src) && $stable(adc_att)))
    else $error("start not one cycle after setup");
  chk_host_capture: assert property (
    fin && own_q == OWN_HOST |=> host_done &&
    {result_hi, result_lo} == $past(scaled))
    else $error("host result not captured");
  chk_hv_div8: assert property (
    fin && adc_att == ADCMS_ATT_DIV8 |-> scaled == {adc_data, 3'h0})
    else $error("div8 scale wrong");
  chk_cur_unscaled: assert property (
    fin && (own_q == OWN_HS || own_q == OWN_LV) |->
    scaled == {3'h0, adc_data})
    else $error("current result scaled");
  chk_vs_div3: assert property (
    fin && adc_att == ADCMS_ATT_DIV3 |-> scaled == 13'(adc_data * 3))
    else $error("div3 scale wrong");
  chk_hv_att: assert property (
    adc_start && adc_src == ADCMS_SRC_HV |->
    adc_att inside {ADCMS_ATT_DIV4, ADCMS_ATT_DIV8})
    else $error("hv attenuation illegal");
  chk_host_first: assert property (
    grant && host_pend_q |=> own_q == OWN_HOST)
    else $error("host not served first");
  chk_ref_range: assert property (
    hv_ref_a <= THR_MAX && hv_ref_b <= THR_MAX)
    else $error("threshold code past last level");
  chk_flag_nofilt: assert property (
    !hv_filt_en && cmp_in[1] |=> hv_flag_b)
    else $error("unfiltered flag late");
  chk_sched_tick: assert property (
    tick_hit |=> hs_pend_q && lv_pend_q)
    else $error("schedule tick lost");
  chk_host_route: assert property (
    host_take ##1 !trim_pend_q && st_q == ST_IDLE |=> own_q == OWN_HOST
    ##1 adc_start)
    else $error("host request not routed");

endmodule : adcms_top

// ---- rtl/adcms_pkg.sv ----
// adcms_pkg: constants shared by the converter measurement sequencer.
// assumes one 100 MHz clock domain and a 10-bit successive converter.
package adcms_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_TIME_US = 64;
  localparam int FILT_CYC = (FILT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int SCHED_PERIOD_DEF = 16'h2710;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int RAW_W = 10;
  localparam int RES_W = 13;
  localparam int RES_HI_W = 8;
  localparam int RES_LO_W = 5;
  localparam int VSEL_W = 4;
  localparam int THR_W = 9;
  localparam int PER_W = 16;
  localparam int AVG_TAPS = 8;
  localparam int AVG_SHIFT = 3;
  localparam int ACC_W = RES_W + AVG_SHIFT;

  // ----------------------------------------------------------------
  // threshold codes for the high-voltage comparators
  // ----------------------------------------------------------------
  localparam int THR_LEVELS = 408;
  localparam logic [THR_W-1:0] THR_MAX = 9'h197;
  localparam logic [THR_W-1:0] THR_RST = 9'h000;

  // ----------------------------------------------------------------
  // converter input selector, attenuation and scale
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCMS_SRC_HS_CUR = 2'h0,
    ADCMS_SRC_LV_CUR = 2'h1,
    ADCMS_SRC_HV = 2'h2,
    ADCMS_SRC_VSENSE = 2'h3
  } adcms_src_e;

  typedef enum logic [1:0] {
    ADCMS_ATT_DIV1 = 2'h0,
    ADCMS_ATT_DIV3 = 2'h1,
    ADCMS_ATT_DIV4 = 2'h2,
    ADCMS_ATT_DIV8 = 2'h3
  } adcms_att_e;

  localparam logic [3:0] MUL_DIV1 = 4'h1;
  localparam logic [3:0] MUL_DIV3 = 4'h3;
  localparam logic [3:0] MUL_DIV4 = 4'h4;
  localparam logic [3:0] MUL_DIV8 = 4'h8;

endpackage : adcms_pkg

// ---- tb/adcms_conv_model.sv ----
// adcms_conv_model: behavioural converter behind the sequencer's
// selector. assumes adc_start is a one-cycle pulse with the selector
// already set; answers after lat cycles (lat must be 1 or more).
`timescale 1ns/100ps
module adcms_conv_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic adc_start,
  input wire logic [1:0] adc_src,
  input wire logic [adcms_pkg::VSEL_W-1:0] adc_vsel,
  input wire logic [adcms_pkg::RAW_W-1:0] raw_base,
  input wire logic [7:0] lat,
  output logic adc_done,
  output logic [adcms_pkg::RAW_W-1:0] adc_data
);
  import adcms_pkg::*;
  // ----------------------------------------------------------------
  // conversion timer and sample
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;
  logic [RAW_W-1:0] samp_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      samp_q <= 10'h000;
      adc_done <= 1'b0;
    end else begin
      adc_done <= 1'b0;
      if (adc_start) begin
        cnt_q <= lat;
        // sample depends on the routed channel, so misrouting shows
        samp_q <= (adc_src == 2'h3) ? (raw_base ^ {6'h00, adc_vsel})
                                    : raw_base;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
        adc_done <= (cnt_q == 8'h01);
      end
    end
  end
  // data only valid with done; otherwise inverted so stale reads fail
  assign adc_data = adc_done ? samp_q : ~samp_q;
endmodule : adcms_conv_model

// ---- tb/tb_top.sv ----
// tb_top: self-checking bench for the converter measurement sequencer.
// assumes adcms_top, adcms_pkg and the converter model are compiled.
`timescale 1ns/100ps
module tb_top;
  import adcms_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0, nrst = 1'b0, host_req = 1'b0, host_att_hi = 1'b0;
  logic [1:0] host_src = 2'h0;
  logic [3:0] host_vsel = 4'h0, trim_vsel = 4'h0;
  logic trim_req = 1'b0, trim_att_hi = 1'b0, sched_en = 1'b0;
  logic [15:0] sched_period = 16'h0040;
  logic [8:0] hv_code_a = 9'h000, hv_code_b = 9'h000;
  logic hv_window_en = 1'b0, hv_filt_en = 1'b0;
  logic hv_cmp_a = 1'b0, hv_cmp_b = 1'b0;
  logic host_busy, host_done, trim_busy, trim_done, adc_start, adc_done;
  logic [7:0] result_hi;
  logic [4:0] result_lo;
  logic [12:0] trim_result, hs_cur_avg, lv_cur_avg;
  logic [1:0] adc_src, adc_att;
  logic [3:0] adc_vsel;
  logic [9:0] adc_data, raw_base = 10'h000;
  logic [8:0] hv_ref_a, hv_ref_b;
  logic hv_flag_a, hv_flag_b, bg_on = 1'b0;
  logic [7:0] lat = 8'h02;
  logic [15:0] acc_hs = 16'h0000, acc_lv = 16'h0000;
  int fails = 0, tests_run = 0, cnt_hs = 0, cnt_lv = 0, seed_v;
  always #5 clk = ~clk;
  adcms_top #(.FILT_CYCLES(8)) adcms_top_inst (
    .clk(clk), .nrst(nrst), .host_req(host_req), .host_src(host_src),
    .host_vsel(host_vsel), .host_att_hi(host_att_hi),
    .host_busy(host_busy), .host_done(host_done),
    .result_hi(result_hi), .result_lo(result_lo), .trim_req(trim_req),
    .trim_vsel(trim_vsel), .trim_att_hi(trim_att_hi),
    .trim_busy(trim_busy), .trim_done(trim_done),
    .trim_result(trim_result), .sched_en(sched_en),
    .sched_period(sched_period), .hs_cur_avg(hs_cur_avg),
    .lv_cur_avg(lv_cur_avg), .adc_start(adc_start), .adc_src(adc_src),
    .adc_vsel(adc_vsel), .adc_att(adc_att), .adc_done(adc_done),
    .adc_data(adc_data), .hv_code_a(hv_code_a), .hv_code_b(hv_code_b),
    .hv_window_en(hv_window_en), .hv_filt_en(hv_filt_en),
    .hv_cmp_a(hv_cmp_a), .hv_cmp_b(hv_cmp_b), .hv_ref_a(hv_ref_a),
    .hv_ref_b(hv_ref_b), .hv_flag_a(hv_flag_a), .hv_flag_b(hv_flag_b));
  adcms_conv_model adcms_conv_model_inst (
    .clk(clk), .nrst(nrst), .adc_start(adc_start), .adc_src(adc_src),
    .adc_vsel(adc_vsel), .raw_base(raw_base), .lat(lat),
    .adc_done(adc_done), .adc_data(adc_data));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic limit(input int n);
    if (n >= 400) begin
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      end_sim();
    end
  endtask : limit
  function automatic logic [8:0] clamp(input logic [8:0] c);
    return (c > THR_MAX) ? THR_MAX : c;
  endfunction : clamp
  // one request, then routing and stored scaled result are checked
  task automatic conv(input bit trim, input logic [1:0] src,
      input logic [3:0] vsel, input logic hi, input bit rt);
    logic [3:0] mul;
    logic [1:0] att;
    logic [15:0] exp;
    int n;
    mul = (src == 2'h2) ? (hi ? MUL_DIV8 : MUL_DIV4)
        : (src == 2'h3 && hi) ? MUL_DIV3 : MUL_DIV1;
    att = (src == 2'h2) ? (hi ? ADCMS_ATT_DIV8 : ADCMS_ATT_DIV4)
        : (hi ? ADCMS_ATT_DIV3 : ADCMS_ATT_DIV1);
    exp = 16'((src == 2'h3) ? (raw_base ^ {6'h00, vsel}) : raw_base);
    exp = exp * 16'(mul);
    if (trim) begin
      trim_vsel = vsel;
      trim_att_hi = hi;
      trim_req = 1'b1;
    end else begin
      host_src = src;
      host_vsel = vsel;
      host_att_hi = hi;
      host_req = 1'b1;
    end
    tick();
    check(16'(trim ? trim_busy : host_busy), 16'h0001);
    if (trim) trim_req = 1'b0;
    else begin
      // a second request while busy must be refused, routing keeps src
      host_src = ~src;
      tick();
      host_req = 1'b0;
    end
    n = 0;
    while (adc_start !== 1'b1 && n < 400) begin tick(); n++; end
    limit(n);
    if (rt) begin
      check(16'(adc_src), 16'(src));
      if (src[1]) check(16'(adc_att), 16'(att));
      if (src == 2'h3) check(16'(adc_vsel), 16'(vsel));
    end
    n = 0;
    while ((trim ? trim_done : host_done) !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    limit(n);
    if (trim) check(16'(trim_result), exp);
    else check(16'({result_hi, result_lo}), exp);
    check(16'(trim ? trim_busy : host_busy), 16'h0000);
  endtask : conv
  // reference weighted average of background current samples
  always @(posedge clk) begin
    if (bg_on && adc_done === 1'b1 && adc_src === 2'h0) begin
      acc_hs <= acc_hs - (acc_hs >> 3) + 16'(adc_data);
      cnt_hs <= cnt_hs + 1;
    end
    if (bg_on && adc_done === 1'b1 && adc_src === 2'h1) begin
      acc_lv <= acc_lv - (acc_lv >> 3) + 16'(adc_data);
      cnt_lv <= cnt_lv + 1;
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0] code;
    seed_v = $urandom(21191);
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(16'({host_busy, host_done, trim_busy, trim_done, adc_start,
        hv_flag_a, hv_flag_b}), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      raw_base = (i == 6) ? 10'h3ff : 10'($urandom);
      lat = (i == 15) ? 8'h28 : 8'($urandom_range(1, 6));
      conv(1'b0, 2'(i), 4'($urandom), i[2], 1'b1);
    end
    for (int i = 0; i < 4; i++) conv(1'b1, 2'h3, 4'($urandom), i[0], 1'b1);
    $display("test host and trim done");
    raw_base = 10'($urandom);
    fork
      conv(1'b0, 2'h2, 4'h0, 1'b1, 1'b1);
      conv(1'b1, 2'h3, 4'h5, 1'b1, 1'b0);
    join
    $display("test contention done");
    for (int i = 0; i < 8; i++) begin
      code = (i == 0) ? 9'h000 : (i == 1) ? 9'h196 : (i == 2) ? 9'h197
           : (i == 3) ? 9'h198 : (i == 4) ? 9'h1ff : 9'($urandom);
      hv_code_a = code;
      hv_code_b = ~code;
      tick();
      tick();
      check(16'(hv_ref_a), 16'(clamp(code)));
      check(16'(hv_ref_b), 16'(clamp(~code)));
    end
    for (int i = 0; i < 8; i++) begin
      hv_cmp_a = 1'($urandom);
      hv_cmp_b = 1'($urandom);
      tick();
      check(16'({hv_flag_a, hv_flag_b}), 16'({hv_cmp_a, hv_cmp_b}));
    end
    hv_window_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {hv_cmp_a, hv_cmp_b} = 2'(i);
      tick();
      tick();
      check(16'({hv_flag_a, hv_flag_b}),
          16'({hv_cmp_b & ~hv_cmp_a, hv_cmp_b}));
    end
    {hv_window_en, hv_filt_en, hv_cmp_a} = 3'h2;
    repeat (12) tick();
    hv_cmp_a = 1'b1;
    repeat (4) tick();
    check(16'(hv_flag_a), 16'h0000);
    repeat (8) tick();
    check(16'(hv_flag_a), 16'h0001);
    hv_cmp_a = 1'b0;
    repeat (3) tick();
    hv_cmp_a = 1'b1;
    repeat (12) tick();
    check(16'(hv_flag_a), 16'h0001);
    $display("test high-voltage flags done");
    bg_on = 1'b1;
    sched_en = 1'b1;
    for (int k = 0; k < 20; k++) begin
      raw_base = 10'($urandom);
      lat = 8'($urandom_range(1, 6));
      repeat (100) tick();
    end
    sched_en = 1'b0;
    repeat (100) tick();
    bg_on = 1'b0;
    check(16'(hs_cur_avg), acc_hs >> 3);
    check(16'(lv_cur_avg), acc_lv >> 3);
    check(16'(cnt_hs > 8 && cnt_lv > 8), 16'h0001);
    $display("test background averaging done");
    nrst = 1'b0;
    tick();
    nrst = 1'b1;
    check(16'({result_hi, result_lo}), 16'h0000);
    check(16'(hs_cur_avg | lv_cur_avg | trim_result), 16'h0000);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb_top
